// file: rtl/sslp_crc8.sv
// checksum over one 16-bit data word, combinational
// assumes the word is the two bytes just sent, high byte first
`timescale 1ns/1ns
`default_nettype none
`include "sslp_defines.svh"
module sslp_crc8 (
  input wire logic [15:0] data,
  output logic [7:0] crc
);
  function automatic logic [7:0] crc_word(input logic [15:0] d);
    logic [7:0] c;
    c = `SSLP_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ `SSLP_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c ^ `SSLP_CRC_XOROUT;
  endfunction : crc_word

  assign crc = crc_word(data);
endmodule : sslp_crc8
`default_nettype wire

// file: rtl/sslp_defines.svh
// constants for the sleep, identifier and checksum command block
// assumes inclusion by bare name from rtl/ files
`ifndef SSLP_DEFINES_SVH
`define SSLP_DEFINES_SVH
`define SSLP_CMD_SLEEP 16'h3677
`define SSLP_CMD_IDENT 16'hE102
`define SSLP_CMD_STOP 16'h3FF9
`define SSLP_CRC_POLY 8'h31
`define SSLP_CRC_INIT 8'hFF
`define SSLP_CRC_XOROUT 8'h00
// product number value is arbitrary; low byte 1x marks final product
`define SSLP_PROD_NUMBER 32'h0A0B_0C10
`define SSLP_FLOW_UNIT 16'h0148
`define SSLP_UNIT_BASE 5'h01
`define SSLP_UNIT_TIME 4'h4
`define SSLP_UNIT_PREFIX 4'h8
`define SSLP_FLOW_SCALE 16'h00AA
`define SSLP_FLOW_OFFSET 16'hA000
`define SSLP_TEMP_SCALE 16'h00C8
`define SSLP_TEMP_OFFSET 16'h0000
`define SSLP_CLK_MHZ 100
`define SSLP_STOP_NS 500000
`define SSLP_STOP_CYC ((`SSLP_STOP_NS * `SSLP_CLK_MHZ) / 1000)
`define SSLP_WAKE_NS 16000000
`define SSLP_WAKE_CYC ((`SSLP_WAKE_NS / 1000) * `SSLP_CLK_MHZ)
`define SSLP_ID_WORDS 6
`endif

// file: rtl/sslp_id_rom.sv
// identifier response words: product number then serial number
// assumes serial is supplied by the top from its calibration inputs
`timescale 1ns/1ns
`default_nettype none
`include "sslp_defines.svh"
module sslp_id_rom (
  input wire logic [2:0] index,
  input wire logic [63:0] serial,
  output logic [15:0] word
);
  wire logic [95:0] id_bits;
  // product number, arbitrary value; low byte 1x marks final product
  assign id_bits = {`SSLP_PROD_NUMBER, serial};
  assign word = (index < 3'(`SSLP_ID_WORDS)) ?
    id_bits[95 - 16 * index -: 16] : 16'h0000;
endmodule : sslp_id_rom
`default_nettype wire

// file: rtl/sslp_pkg.sv
// types for the sleep, identifier and checksum command block
// assumes nothing beyond the constants header
package sslp_pkg;
  typedef enum logic [3:0] {
    SSLP_IDLE = 4'b0001,
    SSLP_MEAS = 4'b0010,
    SSLP_STOPPING = 4'b0100,
    SSLP_SLEEP = 4'b1000
  } sslp_mode_e;
  typedef logic [15:0] sslp_word_t;
endpackage : sslp_pkg

// file: rtl/sslp_top.sv
// What this block does
// - sleep command accepted only from idle
// - soft reset ignored while asleep
// - own address plus write wakes to idle
// - waking address byte is not acknowledged
// - identifier command followed by read returns id
// - identifier command executes only from idle
// - 32-bit product then 64-bit serial words
// - serial decimal: year, week, six-digit sequence
// - product low byte 8x prototype, 1x final
// - checksum follows every 16-bit identifier word; register reads carry none
// - flow is signed, (raw - offset)/scale
// - flow scale 170, offset -24576
// - temperature scale 200, offset zero
// - unit word fields prefix, time, base
// - only unit code 0148
// - stop takes 0.5 ms, commands refused
//
// command layer of the sensor: receives decoded bus events and
// serves the identifier readout and the fixed format words.
// assumes an external byte engine that reports address phases,
// command words and read-byte requests synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "sslp_defines.svh"
module sslp_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic addr_seen,
  input wire logic addr_match,
  input wire logic addr_read,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic reset_req,
  input wire logic meas_start,
  input wire logic rd_req,
  input wire logic [6:0] cal_year,
  input wire logic [5:0] cal_week,
  input wire logic [19:0] cal_seq,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic addr_ack,
  output logic [7:0] rd_byte,
  output logic rd_valid,
  output logic soft_reset,
  output logic cmd_refused,
  output logic [3:0] mode,
  output logic [15:0] reg_rdata
);
  import sslp_pkg::*;

  localparam int STOP_CYC = `SSLP_STOP_CYC;
  localparam int WAKE_CYC = `SSLP_WAKE_CYC;

  sslp_mode_e state;
  sslp_mode_e next_state;
  logic [20:0] timer;
  logic [20:0] next_timer;
  logic waking;
  logic id_armed;
  logic [2:0] word_idx;
  logic [1:0] byte_idx;
  logic [63:0] serial;
  logic [15:0] flow_raw;
  logic [15:0] temp_raw;

  wire logic [15:0] id_word;
  wire logic [7:0] id_crc;
  wire logic [7:0] next_byte;
  wire logic is_idle;
  wire logic cmd_ok;
  wire logic wake_hit;
  wire logic id_done;

  // decimal yywwxxxxxx packed as binary value
  function automatic logic [63:0] ser_dec(input logic [6:0] yy,
                                          input logic [5:0] ww,
                                          input logic [19:0] sq);
    ser_dec = 64'(yy) * 64'd100000000 + 64'(ww) * 64'd1000000 + 64'(sq);
  endfunction : ser_dec

  sslp_id_rom u_rom (
    .index(word_idx),
    .serial(serial),
    .word(id_word)
  );

  sslp_crc8 u_crc (
    .data(id_word),
    .crc(id_crc)
  );

  assign is_idle = (state == SSLP_IDLE) && !waking;
  assign cmd_ok = cmd_valid && is_idle;
  // only own address with write bit is seen while asleep
  assign wake_hit = (state == SSLP_SLEEP) && addr_seen && addr_match &&
                    !addr_read;
  assign id_done = (word_idx == 3'(`SSLP_ID_WORDS - 1)) &&
                   (byte_idx == 2'd2);
  assign next_byte = (byte_idx == 2'd0) ? id_word[15:8] :
                     (byte_idx == 2'd1) ? id_word[7:0] : id_crc;

  always_comb begin
    next_state = state;
    next_timer = timer;
    unique case (state)
      SSLP_IDLE: begin
        if (waking) begin
          next_timer = timer - 21'd1;
        end else if (cmd_valid && cmd_code == `SSLP_CMD_SLEEP) begin
          next_state = SSLP_SLEEP;
        end else if (meas_start) begin
          next_state = SSLP_MEAS;
        end
      end
      SSLP_MEAS: begin
        if (cmd_valid && cmd_code == `SSLP_CMD_STOP) begin
          next_state = SSLP_STOPPING;
          next_timer = 21'(STOP_CYC - 1);
        end
      end
      SSLP_STOPPING: begin
        next_timer = timer - 21'd1;
        if (timer == 21'd0) begin
          next_state = SSLP_IDLE;
        end
      end
      SSLP_SLEEP: begin
        if (wake_hit) begin
          next_state = SSLP_IDLE;
          next_timer = 21'(WAKE_CYC - 1);
        end
      end
      default: begin
        next_state = SSLP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SSLP_IDLE;
      timer <= 21'd0;
      waking <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      if (wake_hit) begin
        waking <= 1'b1;
      end else if (waking && timer == 21'd0) begin
        waking <= 1'b0;
      end
    end
  end

  // identifier readout pointer; sleep drops any pending command
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      id_armed <= 1'b0;
      word_idx <= 3'd0;
      byte_idx <= 2'd0;
    end else if (state == SSLP_SLEEP) begin
      id_armed <= 1'b0;
      word_idx <= 3'd0;
      byte_idx <= 2'd0;
    end else if (cmd_valid) begin
      id_armed <= cmd_ok && cmd_code == `SSLP_CMD_IDENT;
      word_idx <= 3'd0;
      byte_idx <= 2'd0;
    end else if (rd_req && id_armed) begin
      if (id_done) begin
        id_armed <= 1'b0;
      end
      if (byte_idx == 2'd2) begin
        byte_idx <= 2'd0;
        word_idx <= word_idx + 3'd1;
      end else begin
        byte_idx <= byte_idx + 2'd1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial <= 64'h0000_0000_0000_0000;
      rd_byte <= 8'h00;
      rd_valid <= 1'b0;
      addr_ack <= 1'b0;
      soft_reset <= 1'b0;
      cmd_refused <= 1'b0;
      mode <= 4'h0;
    end else begin
      serial <= ser_dec(cal_year, cal_week, cal_seq);
      rd_valid <= rd_req && id_armed;
      rd_byte <= (rd_req && id_armed) ? next_byte : 8'hFF;
      addr_ack <= addr_seen && addr_match && state != SSLP_SLEEP &&
                  state != SSLP_STOPPING && !waking;
      soft_reset <= reset_req && state != SSLP_SLEEP;
      cmd_refused <= cmd_valid && (state == SSLP_STOPPING || waking ||
        (state == SSLP_MEAS && cmd_code != `SSLP_CMD_STOP));
      mode <= state;
    end
  end

  // format registers: 0 flow, 1 temp, 2..5 constants, 6 unit fields
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flow_raw <= 16'h0000;
      temp_raw <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == 4'h0) begin
        flow_raw <= reg_wdata;
      end
      if (reg_wr && reg_addr == 4'h1) begin
        temp_raw <= reg_wdata;
      end
      if (reg_rd) begin
        unique case (reg_addr)
          4'h0: reg_rdata <= flow_raw;
          4'h1: reg_rdata <= temp_raw;
          4'h2: reg_rdata <= `SSLP_FLOW_SCALE;
          4'h3: reg_rdata <= `SSLP_FLOW_OFFSET;
          4'h4: reg_rdata <= `SSLP_TEMP_SCALE;
          4'h5: reg_rdata <= `SSLP_FLOW_UNIT;
          4'h6: reg_rdata <= {3'b000, `SSLP_UNIT_BASE, `SSLP_UNIT_TIME,
                              `SSLP_UNIT_PREFIX};
          4'h7: reg_rdata <= {12'h000, state};
          default: reg_rdata <= 16'h0000;
        endcase
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end
endmodule : sslp_top
`default_nettype wire

// file: tb/sslp_host.sv
// host model: decoded bus events, one cycle each
// assumes events are sampled on the rising ref_clk edge
`timescale 1ns/1ns
`default_nettype none
module sslp_host (
  input wire logic ref_clk,
  output logic addr_seen, addr_match, addr_read, cmd_valid,
  output logic [15:0] cmd_code,
  output logic reset_req, rd_req
);
  initial {addr_seen, addr_match, addr_read, cmd_valid, cmd_code} = '0;
  initial {reset_req, rd_req} = '0;
  // released lines show the inverse of their last value
  task automatic addr(input logic m, input logic r);
    @(posedge ref_clk);
    {addr_seen, addr_match, addr_read} <= {1'b1, m, r};
    @(posedge ref_clk);
    {addr_seen, addr_match, addr_read} <= {1'b0, ~m, ~r};
  endtask : addr
  // command word after a write header
  task automatic cmd(input logic [15:0] c);
    @(posedge ref_clk);
    {cmd_valid, cmd_code} <= {1'b1, c};
    @(posedge ref_clk);
    {cmd_valid, cmd_code} <= {1'b0, ~c};
  endtask : cmd
  task automatic rst();
    @(posedge ref_clk);
    reset_req <= 1'b1;
    @(posedge ref_clk);
    reset_req <= 1'b0;
  endtask : rst
  task automatic rd();
    @(posedge ref_clk);
    rd_req <= 1'b1;
    @(posedge ref_clk);
    rd_req <= 1'b0;
  endtask : rd
endmodule : sslp_host
`default_nettype wire

// file: tb/sslp_top_sva.sv
// port checker for the command block
// assumes a single ref_clk domain, sys_rst active high
`timescale 1ns/1ns
`default_nettype none
`include "sslp_defines.svh"
module sslp_top_chk (
  input wire logic ref_clk, sys_rst, addr_seen, addr_match, addr_read,
  input wire logic cmd_valid, reset_req, rd_req,
  input wire logic [15:0] cmd_code,
  input wire logic addr_ack, rd_valid, soft_reset, cmd_refused,
  input wire logic [3:0] mode
);
  localparam int STOP_CYC = `SSLP_STOP_CYC;
  localparam int WAKE_CYC = `SSLP_WAKE_CYC;
  logic [16:0] stop_cnt;
  logic [20:0] wake_left;
  wire logic wake_evt;
  assign wake_evt = addr_seen && addr_match && !addr_read && mode == 4'h8;
  // cycles spent stopping, and cycles left of the wake wait
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stop_cnt <= 17'd0;
      wake_left <= 21'd0;
    end else begin
      stop_cnt <= (mode == 4'h4) ? stop_cnt + 17'd1 : 17'd0;
      if (wake_evt) begin
        wake_left <= 21'(WAKE_CYC);
      end else if (wake_left != 21'd0) begin
        wake_left <= wake_left - 21'd1;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  own_ack_a: assert property (
    addr_seen && addr_match && !addr_read && mode == 4'h1 &&
    wake_left == 21'd0 |=> addr_ack)
    else $error("own address not acked");
  wake_noack_a: assert property (
    addr_seen && wake_left != 21'd0 |=> !addr_ack)
    else $error("ack during wake wait");
  sleep_ack_a: assert property (
    addr_seen && mode == 4'h8 |=> !addr_ack) else $error("ack in sleep");
  rst_cause_a: assert property (
    soft_reset |-> $past(reset_req) && $past(mode) != 4'h8)
    else $error("bad soft reset");
  sleep_hold_a: assert property (
    addr_seen && mode == 4'h8 && (!addr_match || addr_read) |=> mode == 4'h8)
    else $error("left sleep");
  wake_a: assert property (
    wake_evt |=> ##1 mode == 4'h1)
    else $error("no wake");
  sleep_gate_a: assert property (
    cmd_valid && cmd_code == 16'h3677 && (mode == 4'h2 ||
    (mode == 4'h4 && stop_cnt < 17'(STOP_CYC - 1)))
    |=> ##1 mode != 4'h8) else $error("sleep outside idle");
  meas_refuse_a: assert property (
    cmd_valid && mode == 4'h2 && cmd_code != 16'h3FF9 |=> cmd_refused)
    else $error("command taken in measure");
  stop_refuse_a: assert property (
    cmd_valid && mode == 4'h4 && stop_cnt < 17'(STOP_CYC - 1)
    |=> cmd_refused) else $error("stop not busy");
  stop_len_a: assert property (
    $fell(mode == 4'h4) |-> stop_cnt == 17'(STOP_CYC))
    else $error("stop length wrong");
  stop_hold_a: assert property (
    $rose(mode == 4'h4) |=> (mode == 4'h4) [*8]) else $error("stop short");
  rd_answer_a: assert property (
    !rd_req |=> !rd_valid) else $error("unrequested byte");
endmodule : sslp_top_chk
bind sslp_top sslp_top_chk u_chk (.ref_clk, .sys_rst, .addr_seen,
  .addr_match, .addr_read, .cmd_valid, .reset_req, .rd_req, .cmd_code,
  .addr_ack, .rd_valid, .soft_reset, .cmd_refused, .mode);
`default_nettype wire

// file: tb/sslp_top_tb.sv
// bench: registers, identifier readout, measure refusal, sleep
// assumes the host model drives the decoded bus events
`timescale 1ns/1ns
`default_nettype none
`include "sslp_defines.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
  mismatches++; $display("Error %0t: %h vs %h", $time, a, e); end end
module sslp_top_tb;
  logic ref_clk = 0, sys_rst = 1, meas_start = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0, mode;
  logic [15:0] reg_wdata = 16'h0000, d, cmd_code, reg_rdata;
  logic addr_seen, addr_match, addr_read, cmd_valid, reset_req, rd_req;
  logic addr_ack, rd_valid, soft_reset, cmd_refused;
  logic [7:0] rd_byte;
  logic [6:0] cal_year = 7'h15;
  logic [5:0] cal_week = 6'h1E;
  logic [19:0] cal_seq = 20'h1_E240;
  int mismatches = 0, tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  sslp_host u_host (.ref_clk, .addr_seen, .addr_match, .addr_read,
    .cmd_valid, .cmd_code, .reset_req, .rd_req);
  sslp_top u_sslp_top (.ref_clk, .sys_rst, .addr_seen, .addr_match,
    .addr_read, .cmd_valid, .cmd_code, .reset_req, .meas_start, .rd_req,
    .cal_year, .cal_week, .cal_seq, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .addr_ack, .rd_byte, .rd_valid,
    .soft_reset, .cmd_refused, .mode, .reg_rdata);
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction : crc8
  task automatic rw(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : rw
  task automatic rr(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rr
  task automatic getb(input logic [7:0] e);
    u_host.rd();
    #1 `CHK({rd_valid, rd_byte}, {1'b1, e})
  endtask : getb
  task automatic read_id(input logic [63:0] s);
    logic [95:0] w;
    w = {`SSLP_PROD_NUMBER, s};
    u_host.cmd(16'hE102);
    for (int i = 0; i < 6; i++) begin
      d = w[95 - 16 * i -: 16];
      getb(d[15:8]);
      getb(d[7:0]);
      getb(crc8(d));
    end
    u_host.rd();
    #1 `CHK(rd_valid, 1'b0)
  endtask : read_id
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1 `CHK(mode, 4'h1)
    `CHK(crc8(16'hBEEF), 8'h92)
    rw(4'h0, 16'h8001);
    rr(4'h0, 16'h8001);
    rw(4'h1, 16'hFF38);
    rr(4'h1, 16'hFF38);
    rr(4'h2, 16'h00AA);
    rr(4'h3, 16'hA000);
    rr(4'h4, 16'h00C8);
    rr(4'h5, 16'h0148);
    rr(4'h6, 16'h0148);
    rr(4'h7, 16'h0001);
    u_host.addr(1'b1, 1'b0);
    #1 `CHK(addr_ack, 1'b1)
    u_host.rst();
    #1 `CHK(soft_reset, 1'b1)
    // serial 21 30 123456 in decimal
    read_id(64'h0000_0000_7EF7_1AC0);
    @(posedge ref_clk);
    cal_year <= 7'h63;
    cal_week <= 6'h35;
    cal_seq <= 20'hF_423F;
    // serial 99 53 999999 in decimal
    read_id(64'h0000_0002_514D_FC7F);
    @(posedge ref_clk);
    meas_start <= 1'b1;
    @(posedge ref_clk);
    meas_start <= 1'b0;
    u_host.cmd(16'hE102);
    #1 `CHK(cmd_refused, 1'b1)
    u_host.cmd(16'h3677);
    #1 `CHK(mode, 4'h2)
    u_host.cmd(16'h3FF9);
    u_host.cmd(16'h3677);
    #1 `CHK({cmd_refused, mode}, 5'h14)
    repeat (50010) @(posedge ref_clk);
    #1 `CHK(mode, 4'h1)
    u_host.cmd(16'h3677);
    @(posedge ref_clk);
    #1 `CHK(mode, 4'h8)
    u_host.rst();
    #1 `CHK(soft_reset, 1'b0)
    u_host.addr(1'b1, 1'b1);
    #1 `CHK({addr_ack, mode}, 5'h08)
    u_host.addr(1'b1, 1'b0);
    #1 `CHK(addr_ack, 1'b0)
    @(posedge ref_clk);
    #1 `CHK(mode, 4'h1)
    u_host.addr(1'b1, 1'b0);
    #1 `CHK(addr_ack, 1'b0)
    u_host.cmd(16'hE102);
    #1 `CHK(cmd_refused, 1'b1)
    give_verdict();
  end
endmodule : sslp_top_tb
`default_nettype wire
